// ===== core/mse_top.sv
// Marker search engine: trace store, command sequencer and scan logic
`timescale 1ns/1ps
`include "mse_cfg.svh"
module mse_top import mse_pkg::*; #(
  parameter int NPTS   = 1000,
  parameter int AMP_W  = 12,
  parameter int FREQ_W = 40,
  parameter int IDX_W  = $clog2(NPTS)
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // Trace store write port
  input  wire logic                    trace_wr_en,
  input  wire logic        [IDX_W-1:0] trace_wr_addr,
  input  wire logic signed [AMP_W-1:0] trace_wr_data,
  // Command port
  input  wire logic                    cmd_valid,
  input  wire mse_cmd_type             cmd_code,
  input  wire logic signed [AMP_W-1:0] cmd_num,
  input  wire logic                    cmd_auto,
  input  wire logic                    cmd_units_given,
  input  wire logic                    cmd_ranged,
  input  wire logic       [FREQ_W-1:0] cmd_f_lo,
  input  wire logic       [FREQ_W-1:0] cmd_f_hi,
  // Instrument settings
  input  wire logic                    search_failure_report_flag,
  input  wire logic        [1:0]       signal_type_select,
  input  wire logic                    zero_span_mode,
  input  wire logic                    max_span_mode,
  input  wire logic                    marker_off,
  input  wire logic       [FREQ_W-1:0] disp_start,
  input  wire logic       [FREQ_W-1:0] disp_step,
  input  wire logic signed [AMP_W-1:0] ref_unit_offset,
  input  wire logic signed [AMP_W-1:0] sensitivity,
  input  wire logic        [7:0]       attenuation,
  input  wire logic        [1:0]       video_filter,
  // Results
  output logic                         cmd_ready_q,
  output logic                         cmd_done_q,
  output logic             [IDX_W-1:0] marker_idx_q,
  output logic                         marker_single_q,
  output logic   [`MSE_FOUND_W-1:0]    found_q,
  output logic                         warn_valid_q,
  output logic             [7:0]       warn_code_q,
  output logic                         err_valid_q,
  output logic             [7:0]       err_code_q,
  output logic                         centre_refused_q,
  output logic                         marker_to_centre_q,
  output logic             [IDX_W-1:0] centre_idx_q,
  output logic             [3:0]       macro_bytes_q,
  output logic signed      [AMP_W-1:0] search_threshold_q,
  output logic                         threshold_auto_q,
  output logic             [1:0]       signal_type_q
);

  localparam int EW = AMP_W + 2;

  // Elaboration guard
  if (NPTS < 3 || (1 << IDX_W) < NPTS) begin : g_bad_size
    $error("mse_top: NPTS must be at least 3 and fit in IDX_W");
  end

  //--------------------------------------------------------------------
  // Storage and helpers
  //--------------------------------------------------------------------
  logic signed [AMP_W-1:0] trace_mem [NPTS];

  // Macro storage charge of each command
  function automatic logic [3:0] macro_bytes(input mse_cmd_type c, input logic ranged);
    unique case (c)
      MSE_CMD_MAXIMUM, MSE_CMD_MINIMUM:
        macro_bytes = ranged ? `MSE_BYTES_RANGE : `MSE_BYTES_SHORT;
      MSE_CMD_SET_THRESHOLD:
        macro_bytes = `MSE_BYTES_THRESHOLD;
      MSE_CMD_MOVE_LEFT_DB, MSE_CMD_MOVE_RIGHT_DB:
        macro_bytes = `MSE_BYTES_MOVE_DB;
      default:
        macro_bytes = `MSE_BYTES_SHORT;
    endcase
  endfunction : macro_bytes

  // Result slot of commands that keep a found flag
  function automatic logic slot_of(input mse_cmd_type c, input int slot);
    unique case (c)
      MSE_CMD_NEXT_LEFT:     slot_of = (slot == `MSE_FOUND_LEFT);
      MSE_CMD_NEXT_RIGHT:    slot_of = (slot == `MSE_FOUND_RIGHT);
      MSE_CMD_THR_PEAK:      slot_of = (slot == `MSE_FOUND_THR_PEAK);
      MSE_CMD_MOVE_LEFT_DB:  slot_of = (slot == `MSE_FOUND_MOVE_LEFT);
      MSE_CMD_MOVE_RIGHT_DB: slot_of = (slot == `MSE_FOUND_MOVE_RIGHT);
      default:               slot_of = 1'b0;
    endcase
  endfunction : slot_of

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  mse_state_type           st_q;
  mse_cmd_type             cmd_q;
  logic        [IDX_W-1:0] scan_idx_q;
  logic       [FREQ_W-1:0] pt_freq_q;
  logic                    best_ok_q;
  logic        [IDX_W-1:0] best_idx_q;
  logic signed    [EW-1:0] best_val_q;
  logic signed    [EW-1:0] ref_val_q;
  logic signed [AMP_W-1:0] num_q;
  logic                    ranged_q;
  logic       [FREQ_W-1:0] f_lo_q;
  logic       [FREQ_W-1:0] f_hi_q;
  logic                    have_pk_q;
  logic signed    [EW-1:0] pk_val_q;
  logic        [IDX_W-1:0] pk_idx_q;
  logic signed    [EW-1:0] lo_min_q;

  logic                    accept;
  logic                    is_search;
  logic                    range_outside;
  logic                    in_window;
  logic                    last_pt;
  logic signed    [EW-1:0] v;
  logic signed    [EW-1:0] thr;
  logic signed    [EW-1:0] target;
  logic                    reach;
  logic                    cand_ev;
  logic                    hit;
  logic signed [AMP_W-1:0] thr_w;

  assign accept    = cmd_valid && cmd_ready_q;
  assign is_search = (cmd_code != MSE_CMD_SET_THRESHOLD);
  assign v         = EW'(trace_mem[scan_idx_q]);
  assign thr       = EW'(thr_w);
  assign target    = EW'(ref_val_q + EW'(num_q));
  assign last_pt   = (scan_idx_q == IDX_W'(NPTS - 1));

  //--------------------------------------------------------------------
  // Sub-blocks
  //--------------------------------------------------------------------
  mse_threshold #(.AMP_W(AMP_W)) u_thr (
    .sys_clk         (sys_clk),
    .reset           (reset),
    .set_en          (accept && cmd_code == MSE_CMD_SET_THRESHOLD),
    .set_auto        (cmd_auto),
    .set_value       (cmd_num),
    .set_units_given (cmd_units_given),
    .ref_unit_offset (ref_unit_offset),
    .sensitivity     (sensitivity),
    .attenuation     (attenuation),
    .video_filter    (video_filter),
    .threshold_q     (thr_w),
    .auto_q          (threshold_auto_q)
  );

  mse_window #(.FREQ_W(FREQ_W), .NPTS(NPTS)) u_win (
    .f_lo       (f_lo_q),
    .f_hi       (f_hi_q),
    .ranged     (ranged_q),
    .disp_start (disp_start),
    .disp_step  (disp_step),
    .pt_freq    (pt_freq_q),
    .outside    (range_outside),
    .in_window  (in_window)
  );

  //--------------------------------------------------------------------
  // Trace store
  //--------------------------------------------------------------------
  // Writes land at any time; a write during a scan is seen if ahead of it
  always_ff @(posedge sys_clk) begin
    if (trace_wr_en) begin
      trace_mem[trace_wr_addr] <= trace_wr_data;
    end
  end

  //--------------------------------------------------------------------
  // Per-point decisions
  //--------------------------------------------------------------------
  // Crossing test for dB moves: up means at or above target, down at or below
  assign reach   = (num_q >= 0) ? (v >= target) : (v <= target);
  // A running peak is confirmed once the trace falls 3 dB below it
  assign cand_ev = have_pk_q && (v <= pk_val_q - $signed(EW'(`MSE_CAND_DROP_DB)));

  // Whether this point becomes the new best; strict compares keep leftmost
  always_comb begin
    hit = 1'b0;
    unique case (cmd_q)
      MSE_CMD_MAXIMUM:
        hit = in_window && (!best_ok_q || v > best_val_q);
      MSE_CMD_MINIMUM:
        hit = in_window && (!best_ok_q || v < best_val_q);
      MSE_CMD_THR_PEAK, MSE_CMD_PEAK_CENTRE:
        hit = (v > thr) && (!best_ok_q || v > best_val_q);
      MSE_CMD_MOVE_LEFT_DB:
        hit = (scan_idx_q < marker_idx_q) && reach;
      MSE_CMD_MOVE_RIGHT_DB:
        hit = (scan_idx_q > marker_idx_q) && reach && !best_ok_q;
      MSE_CMD_NEXT_LEFT:
        hit = cand_ev && (pk_idx_q < marker_idx_q);
      MSE_CMD_NEXT_RIGHT:
        hit = cand_ev && (pk_idx_q > marker_idx_q) && !best_ok_q;
      default:
        hit = 1'b0;
    endcase
  end

  //--------------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------------
  // One point per cycle, left to right, then one cycle to settle results
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= MSE_ST_IDLE;
    end else begin
      unique case (st_q)
        MSE_ST_IDLE: begin
          if (accept && is_search) begin
            if (cmd_code == MSE_CMD_PEAK_CENTRE && (zero_span_mode || max_span_mode)) begin
              st_q <= MSE_ST_IDLE;
            end else if ((cmd_code == MSE_CMD_MAXIMUM || cmd_code == MSE_CMD_MINIMUM)
                         && cmd_ranged) begin
              st_q <= MSE_ST_FETCH; // Range checked once the arguments are held
            end else begin
              st_q <= MSE_ST_FETCH;
            end
          end
        end
        MSE_ST_FETCH: st_q <= range_outside ? MSE_ST_DONE : MSE_ST_SCAN;
        MSE_ST_SCAN:  st_q <= last_pt ? MSE_ST_DONE : MSE_ST_SCAN;
        MSE_ST_DONE:  st_q <= MSE_ST_IDLE;
      endcase
    end
  end

  // Command capture
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_q    <= MSE_CMD_NEXT_LEFT;
      num_q    <= '0;
      ranged_q <= 1'b0;
      f_lo_q   <= '0;
      f_hi_q   <= '0;
    end else if (accept && is_search) begin
      cmd_q    <= cmd_code;
      num_q    <= cmd_num;
      ranged_q <= cmd_ranged && (cmd_code == MSE_CMD_MAXIMUM || cmd_code == MSE_CMD_MINIMUM);
      f_lo_q   <= cmd_f_lo;
      f_hi_q   <= cmd_f_hi;
    end
  end

  // Scan position and its frequency
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scan_idx_q <= '0;
      pt_freq_q  <= '0;
    end else if (st_q == MSE_ST_FETCH) begin
      scan_idx_q <= '0;
      pt_freq_q  <= disp_start;
    end else if (st_q == MSE_ST_SCAN && !last_pt) begin
      scan_idx_q <= scan_idx_q + 1'b1;
      pt_freq_q  <= FREQ_W'(pt_freq_q + disp_step);
    end
  end

  // Reference amplitude for dB moves, read at the marker before scanning
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ref_val_q <= '0;
    end else if (st_q == MSE_ST_FETCH) begin
      ref_val_q <= EW'(trace_mem[marker_idx_q]);
    end
  end

  // Candidate tracker: needs a 3 dB dip before and after a peak over threshold
  always_ff @(posedge sys_clk) begin
    if (reset || st_q == MSE_ST_FETCH) begin
      have_pk_q <= 1'b0;
      pk_val_q  <= '0;
      pk_idx_q  <= '0;
      lo_min_q  <= {1'b0, {(EW-1){1'b1}}};
    end else if (st_q == MSE_ST_SCAN) begin
      if (!have_pk_q) begin
        // Signed drop keeps the dip test an amplitude compare, not a bit-pattern one
        if (v > thr && lo_min_q <= v - $signed(EW'(`MSE_CAND_DROP_DB))) begin
          have_pk_q <= 1'b1;
          pk_val_q  <= v;
          pk_idx_q  <= scan_idx_q;
        end else if (v < lo_min_q) begin
          lo_min_q <= v;
        end
      end else if (cand_ev) begin
        have_pk_q <= 1'b0;
        lo_min_q  <= v;
      end else if (v > pk_val_q) begin
        pk_val_q <= v;
        pk_idx_q <= scan_idx_q;
      end
    end
  end

  // Best point so far
  always_ff @(posedge sys_clk) begin
    if (reset || st_q == MSE_ST_FETCH) begin
      best_ok_q  <= 1'b0;
      best_idx_q <= '0;
      best_val_q <= '0;
    end else if (st_q == MSE_ST_SCAN && hit) begin
      best_ok_q  <= 1'b1;
      best_idx_q <= (cmd_q == MSE_CMD_NEXT_LEFT || cmd_q == MSE_CMD_NEXT_RIGHT)
                    ? pk_idx_q : scan_idx_q;
      best_val_q <= v;
    end
  end

  //--------------------------------------------------------------------
  // Results and outputs
  //--------------------------------------------------------------------
  // Marker moves only on success; otherwise it stays put
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      marker_idx_q <= '0;
    end else if (st_q == MSE_ST_DONE && best_ok_q) begin
      marker_idx_q <= best_idx_q;
    end
  end

  // Single marker is switched on by any search; off only from outside
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      marker_single_q <= 1'b0;
    end else if (accept && is_search) begin
      marker_single_q <= 1'b1;
    end else if (marker_off) begin
      marker_single_q <= 1'b0;
    end
  end

  // Found flags read FAILED from reset until their command runs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      found_q <= '0;
    end else if (st_q == MSE_ST_DONE) begin
      for (int s = 0; s < `MSE_FOUND_W; s++) begin
        if (slot_of(cmd_q, s)) begin
          found_q[s] <= best_ok_q;
        end
      end
    end
  end

  // Warning, error and centring pulses
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      warn_valid_q       <= 1'b0;
      warn_code_q        <= '0;
      err_valid_q        <= 1'b0;
      err_code_q         <= '0;
      marker_to_centre_q <= 1'b0;
      centre_idx_q       <= '0;
      centre_refused_q   <= 1'b0;
      cmd_done_q         <= 1'b0;
    end else begin
      warn_valid_q       <= 1'b0;
      err_valid_q        <= 1'b0;
      marker_to_centre_q <= 1'b0;
      centre_refused_q   <= 1'b0;
      cmd_done_q         <= 1'b0;
      if (st_q == MSE_ST_IDLE && accept && cmd_code == MSE_CMD_PEAK_CENTRE
          && (zero_span_mode || max_span_mode)) begin
        centre_refused_q <= 1'b1;
        cmd_done_q       <= 1'b1;
      end
      if (st_q == MSE_ST_DONE) begin
        cmd_done_q <= 1'b1;
        if (ranged_q && range_outside) begin
          err_valid_q <= 1'b1;
          err_code_q  <= `MSE_ERR_RANGE_OFF;
        end else if (!best_ok_q && search_failure_report_flag
                     && cmd_q != MSE_CMD_MAXIMUM && cmd_q != MSE_CMD_MINIMUM) begin
          warn_valid_q <= 1'b1;
          warn_code_q  <= `MSE_WARN_NOT_FOUND;
        end
        if (cmd_q == MSE_CMD_PEAK_CENTRE && best_ok_q) begin
          marker_to_centre_q <= 1'b1;
          centre_idx_q       <= best_idx_q;
        end
      end
    end
  end

  // Ready only while idle; threshold setting completes at acceptance
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cmd_ready_q   <= 1'b0;
      macro_bytes_q <= '0;
    end else begin
      cmd_ready_q <= (st_q == MSE_ST_IDLE && !(accept && is_search)) || st_q == MSE_ST_DONE;
      if (accept) begin
        macro_bytes_q <= macro_bytes(cmd_code, cmd_ranged);
      end
    end
  end

  // Registered copies of the shared settings for readback
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      search_threshold_q <= '0;
      signal_type_q      <= `MSE_SIGNAL_TYPE_SELECT_CW;
    end else begin
      search_threshold_q <= thr_w;
      // Stored only; the classifier treats every candidate as a signal
      signal_type_q      <= signal_type_select;
    end
  end

endmodule : mse_top

// ===== core/mse_cfg.svh
// Constants for the marker search engine: codes, offsets and storage sizes
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`ifndef MSE_CFG_SVH
`define MSE_CFG_SVH

`define MSE_WARN_NOT_FOUND   8'h82
`define MSE_ERR_RANGE_OFF    8'h1c
`define MSE_CAND_DROP_DB     8'h03
`define MSE_VF_OFFSET_NONE   8'h0a
`define MSE_VF_OFFSET_WIDE   8'h04
`define MSE_VF_OFFSET_NARROW 8'h02
`define MSE_SIGNAL_TYPE_SELECT_CW         2'h0
`define MSE_SIGNAL_TYPE_SELECT_PULSE      2'h1
`define MSE_SIGNAL_TYPE_SELECT_SPURS      2'h2
`define MSE_VFILT_NONE       2'h0
`define MSE_VFILT_WIDE       2'h1
`define MSE_VFILT_NARROW     2'h2
`define MSE_BYTES_SHORT      4'h1
`define MSE_BYTES_MOVE_DB    4'h3
`define MSE_BYTES_THRESHOLD  4'h4
`define MSE_BYTES_RANGE      4'hc
`define MSE_FOUND_LEFT       0
`define MSE_FOUND_RIGHT      1
`define MSE_FOUND_THR_PEAK   2
`define MSE_FOUND_MOVE_LEFT  3
`define MSE_FOUND_MOVE_RIGHT 4
`define MSE_FOUND_W          5

`endif

// ===== core/mse_pkg.sv
// Types shared by the marker search engine modules
package mse_pkg;

  // Commands accepted on the command port
  typedef enum logic [3:0] {
    MSE_CMD_NEXT_LEFT,
    MSE_CMD_NEXT_RIGHT,
    MSE_CMD_THR_PEAK,
    MSE_CMD_PEAK_CENTRE,
    MSE_CMD_MAXIMUM,
    MSE_CMD_MINIMUM,
    MSE_CMD_SET_THRESHOLD,
    MSE_CMD_MOVE_LEFT_DB,
    MSE_CMD_MOVE_RIGHT_DB
  } mse_cmd_type;

  // Sequencer states
  typedef enum logic [1:0] {
    MSE_ST_IDLE,
    MSE_ST_FETCH,
    MSE_ST_SCAN,
    MSE_ST_DONE
  } mse_state_type;

endpackage : mse_pkg

// ===== core/mse_threshold.sv
// Search threshold keeper: automatic or fixed level in whole dB
`timescale 1ns/1ps
`include "mse_cfg.svh"
module mse_threshold import mse_pkg::*; #(
  parameter int AMP_W = 12
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic                    set_en,
  input  wire logic                    set_auto,
  input  wire logic signed [AMP_W-1:0] set_value,
  input  wire logic                    set_units_given,
  input  wire logic signed [AMP_W-1:0] ref_unit_offset,
  input  wire logic signed [AMP_W-1:0] sensitivity,
  input  wire logic        [7:0]       attenuation,
  input  wire logic        [1:0]       video_filter,
  output logic signed      [AMP_W-1:0] threshold_q,
  output logic                         auto_q
);

  logic signed [AMP_W-1:0] vf_offset;
  logic signed [AMP_W-1:0] auto_level;
  logic signed [AMP_W-1:0] fixed_level;

  // Video filter offset for the automatic level
  always_comb begin
    unique case (video_filter)
      `MSE_VFILT_WIDE:   vf_offset = AMP_W'(`MSE_VF_OFFSET_WIDE);
      `MSE_VFILT_NARROW: vf_offset = AMP_W'(`MSE_VF_OFFSET_NARROW);
      default:           vf_offset = AMP_W'(`MSE_VF_OFFSET_NONE);
    endcase
  end

  assign auto_level  = AMP_W'(sensitivity + $signed({1'b0, attenuation}) + vf_offset);
  // Bare numbers are in reference units; shift them onto the absolute scale
  assign fixed_level = set_units_given ? set_value : AMP_W'(set_value + ref_unit_offset);

  // Mode flag, automatic out of reset
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      auto_q <= 1'b1;
    end else if (set_en) begin
      auto_q <= set_auto;
    end
  end

  // Level is whole dB only, so every change is a 1 dB multiple
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      threshold_q <= '0;
    end else if (set_en && !set_auto) begin
      threshold_q <= fixed_level;
    end else if (auto_q || (set_en && set_auto)) begin
      threshold_q <= auto_level;
    end
  end

endmodule : mse_threshold

// ===== core/mse_window.sv
// Frequency window test for range-limited maximum and minimum searches
`timescale 1ns/1ps
module mse_window #(
  parameter int FREQ_W = 40,
  parameter int NPTS   = 1000
) (
  input  wire logic [FREQ_W-1:0] f_lo,
  input  wire logic [FREQ_W-1:0] f_hi,
  input  wire logic              ranged,
  input  wire logic [FREQ_W-1:0] disp_start,
  input  wire logic [FREQ_W-1:0] disp_step,
  input  wire logic [FREQ_W-1:0] pt_freq,
  output logic                   outside,
  output logic                   in_window
);

  logic [FREQ_W-1:0] disp_stop;

  // Last displayed point; a product avoids a divider on the hot path
  assign disp_stop = FREQ_W'(disp_start + disp_step * FREQ_W'(NPTS - 1));
  assign outside   = ranged && ((f_hi < disp_start) || (f_lo > disp_stop));
  // Only points inside both ranges take part
  assign in_window = !ranged || ((pt_freq >= f_lo) && (pt_freq <= f_hi));

endmodule : mse_window

// ===== tb/mse_chk.sv
// Port checker for the marker search engine, bound to its top module
`timescale 1ns/1ps
module mse_chk import mse_pkg::*; #(
  parameter int NPTS  = 1000,
  parameter int IDX_W = 10
) (
  input wire logic sys_clk, reset, cmd_valid, cmd_ready_q, cmd_ranged, cmd_done_q,
  input wire mse_cmd_type cmd_code,
  input wire logic zero_span_mode, max_span_mode, search_failure_report_flag,
  input wire logic warn_valid_q, err_valid_q, centre_refused_q, marker_to_centre_q,
  input wire logic threshold_auto_q, marker_single_q,
  input wire logic [7:0] warn_code_q, err_code_q,
  input wire logic [3:0] macro_bytes_q,
  input wire logic [IDX_W-1:0] marker_idx_q, centre_idx_q
);
  // Scan of every point plus fetch and wrap-up, with slack
  localparam int LAT = NPTS + 4;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire tk = cmd_valid && cmd_ready_q;
  //----------------------------------------------------------------------
  // Result codes, marker behaviour, macro bytes, search latency and threshold mode
  //----------------------------------------------------------------------
  a_warn_code: assert property (warn_valid_q |-> warn_code_q == 8'h82) else $error("warn code");
  a_warn_flag: assert property (warn_valid_q |-> $past(search_failure_report_flag))
    else $error("warn without flag");
  a_err_code: assert property (err_valid_q |-> err_code_q == 8'h1c) else $error("err code");
  a_fail_stay: assert property (warn_valid_q |-> $stable(marker_idx_q)) else $error("moved");
  a_single_on: assert property (cmd_done_q && !centre_refused_q |-> marker_single_q)
    else $error("marker not single");
  a_span_refuse: assert property (tk && cmd_code == MSE_CMD_PEAK_CENTRE &&
    (zero_span_mode || max_span_mode) |=> ##[0:2] centre_refused_q) else $error("not refused");
  a_refuse_hold: assert property (centre_refused_q |-> $stable(marker_idx_q))
    else $error("refusal moved marker");
  a_centre_pos: assert property (marker_to_centre_q |-> centre_idx_q == marker_idx_q)
    else $error("centre index");
  a_range_bytes: assert property (tk && cmd_ranged && (cmd_code == MSE_CMD_MAXIMUM ||
    cmd_code == MSE_CMD_MINIMUM) |=> ##[0:2] macro_bytes_q == 4'hc) else $error("bytes");
  a_search_ends: assert property (tk && cmd_code == MSE_CMD_MAXIMUM |=> ##[0:LAT] cmd_done_q)
    else $error("search hung");
  a_auto_boot: assert property ($fell(reset) |-> threshold_auto_q) else $error("not auto");
endmodule : mse_chk

bind mse_top mse_chk #(.NPTS(NPTS), .IDX_W(IDX_W)) chk (.*);

// ===== tb/mse_host.sv
// Bus controller model: issues one marker command at a time
`timescale 1ns/1ps
module mse_host import mse_pkg::*; (
  input wire logic sys_clk, cmd_ready_q,
  output mse_cmd_type cmd_code,
  output logic cmd_valid, cmd_ranged, cmd_units_given, cmd_auto,
  output logic signed [11:0] cmd_num,
  output logic [39:0] cmd_f_lo, cmd_f_hi
);
  initial {cmd_valid, cmd_ranged, cmd_units_given, cmd_auto, cmd_num, cmd_f_lo, cmd_f_hi} = '0;
  initial cmd_code = MSE_CMD_MAXIMUM;
  // Request held until an edge sees ready; bounded so a dead port is reported
  task automatic send(mse_cmd_type c, logic signed [11:0] v, logic r, logic u,
                      logic [39:0] lo, logic [39:0] hi, output logic ok);
    cmd_code = c;
    cmd_num = v;
    cmd_ranged = r;
    cmd_units_given = u;
    {cmd_f_lo, cmd_f_hi} = {lo, hi};
    cmd_valid = 1;
    ok = 0;
    for (int n = 0; n < 99 && !ok; n++) @(posedge sys_clk) ok = cmd_ready_q;
    #1 cmd_valid = 0;
  endtask : send
endmodule : mse_host

// ===== tb/testbench.sv
// Self-checking bench for the marker search engine
`timescale 1ns/1ps
`define CK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %0d got %0d", n, e, g); end end
module testbench import mse_pkg::*; ();
  logic sys_clk = 0, reset = 1, trace_wr_en = 0, search_failure_report_flag = 0;
  logic zero_span_mode = 0, max_span_mode = 0, marker_off = 0;
  logic [1:0] signal_type_select = 0, video_filter = 0, signal_type_q;
  logic [3:0] trace_wr_addr = 0, marker_idx_q, centre_idx_q, macro_bytes_q;
  logic signed [11:0] trace_wr_data = 0, tr[16], search_threshold_q;
  logic signed [11:0] ref_unit_offset = 5, sensitivity = -100;
  logic [7:0] attenuation = 20, warn_code_q, err_code_q;
  logic [39:0] disp_start = 1000, disp_step = 10, cmd_f_lo, cmd_f_hi;
  mse_cmd_type cmd_code;
  logic signed [11:0] cmd_num;
  logic cmd_valid, cmd_ready_q, cmd_ranged, cmd_units_given, cmd_auto, cmd_done_q;
  logic marker_single_q, warn_valid_q, err_valid_q, centre_refused_q, marker_to_centre_q;
  logic threshold_auto_q;
  logic [4:0] found_q;
  int bad_count = 0, check_count = 0, m;
  // Small trace keeps every scan short
  mse_top #(.NPTS(16)) uut (.*);
  mse_host host (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  //----------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic load();
    for (int i = 0; i < 16; i++) begin
      {trace_wr_en, trace_wr_addr, trace_wr_data} = {1'b1, 4'(i), tr[i]};
      @(posedge sys_clk) #1;
    end
    trace_wr_en = 0;
  endtask : load
  // Leftmost extreme over an index span, strict compare keeps the first
  function automatic int best(int lo, int hi, bit mx);
    best = lo;
    for (int i = lo; i <= hi; i++) if (mx ? tr[i] > tr[best] : tr[i] < tr[best]) best = i;
  endfunction : best
  task automatic cmd(mse_cmd_type c, int v = 0, bit r = 0, bit u = 1, int lo = 0, int hi = 0);
    logic ok;
    int k;
    host.send(c, 12'(v), r, u, 40'(lo), 40'(hi), ok);
    k = 0;
    if (c == MSE_CMD_SET_THRESHOLD) repeat (3) @(posedge sys_clk) #1;
    else while (k < 99 && cmd_done_q !== 1'b1) begin @(posedge sys_clk) #1; k++; end
    if (!ok || k == 99) begin bad_count++; end_sim(); end
  endtask : cmd
  //----------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------
  initial begin
    void'($urandom(32'hb11d));
    signal_type_select = 2'($urandom % 3);
    repeat (6) @(posedge sys_clk);
    #1 reset = 0;
    repeat (4) @(posedge sys_clk) #1;
    `CK("found", 0, found_q)
    `CK("auto", 1, threshold_auto_q)
    `CK("thr", -70, search_threshold_q)
    `CK("type", signal_type_select, signal_type_q)
    foreach (tr[i]) tr[i] = 12'(-60 + $urandom % 8);
    load();
    for (int d = 0; d < 2; d++) begin
      marker_off = 1;
      @(posedge sys_clk) #1 marker_off = 0;
      cmd(mse_cmd_type'(4 + d));
      `CK("marker", best(0, 15, !d), marker_idx_q)
      `CK("single", 1, marker_single_q)
      cmd(mse_cmd_type'(4 + d), 0, 1, 1, 1075, 1115);
      `CK("ranged", best(8, 11, !d), marker_idx_q)
    end
    m = best(8, 11, 0);
    cmd(MSE_CMD_MINIMUM, 0, 1, 1, 5000, 6000);
    `CK("err", 1, err_valid_q)
    cmd(MSE_CMD_SET_THRESHOLD, -40);
    `CK("thr", -40, search_threshold_q)
    search_failure_report_flag = 1;
    cmd(MSE_CMD_THR_PEAK);
    `CK("warn", 1, warn_valid_q)
    `CK("stay", m, marker_idx_q)
    cmd(MSE_CMD_SET_THRESHOLD, -65, 0, 0);
    `CK("thr", -60, search_threshold_q)
    cmd(MSE_CMD_THR_PEAK);
    m = best(0, 15, 1);
    `CK("peak", m, marker_idx_q)
    for (int s = 1; s < 3; s++) begin
      {max_span_mode, zero_span_mode} = 2'(s);
      cmd(MSE_CMD_PEAK_CENTRE);
      `CK("refused", 1, centre_refused_q)
    end
    {max_span_mode, zero_span_mode} = 0;
    cmd(MSE_CMD_PEAK_CENTRE);
    `CK("centre", 1, marker_to_centre_q)
    // Back to automatic; the level then follows the video filter setting
    host.cmd_auto = 1;
    video_filter = 1;
    cmd(MSE_CMD_SET_THRESHOLD);
    host.cmd_auto = 0;
    `CK("auto wide", -76, search_threshold_q)
    `CK("auto on", 1, threshold_auto_q)
    video_filter = 2;
    repeat (3) @(posedge sys_clk) #1;
    `CK("auto narrow", -78, search_threshold_q)
    // Two isolated peaks on a flat floor for the signal and dB moves
    foreach (tr[i]) tr[i] = -90;
    tr[4] = -40;
    tr[11] = -30;
    load();
    cmd(MSE_CMD_SET_THRESHOLD, -60);
    cmd(MSE_CMD_MAXIMUM);
    cmd(MSE_CMD_NEXT_LEFT);
    `CK("left", 4, marker_idx_q)
    cmd(MSE_CMD_NEXT_RIGHT);
    `CK("right", 11, marker_idx_q)
    cmd(MSE_CMD_NEXT_RIGHT);
    `CK("nofind", 11, marker_idx_q)
    `CK("found", 5'h05, found_q)
    cmd(MSE_CMD_MOVE_LEFT_DB, -60);
    `CK("mvleft", 10, marker_idx_q)
    cmd(MSE_CMD_MOVE_RIGHT_DB, 50);
    `CK("mvright", 11, marker_idx_q)
    cmd(MSE_CMD_MOVE_RIGHT_DB, 100);
    `CK("found", 5'h0d, found_q)
    end_sim();
  end
endmodule : testbench
